// ===== rtl/wsi_pkg.sv
// Purpose: constants for the secondary interrupt status and mask block
// Assumes: 32-bit register words, ten transmit queues
// Notes:   offsets are byte addresses on the host register port
package wsi_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned NUM_QUEUES = 10;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] OFF_SEC_STATUS_UBB   = 16'h008C;
  localparam logic [15:0] OFF_SEC_STATUS_RATE  = 16'h0090;
  localparam logic [15:0] OFF_SEC_STATUS_TRIG  = 16'h0094;
  localparam logic [15:0] OFF_PRIMARY_MASK     = 16'h00A0;
  localparam logic [15:0] OFF_SEC_MASK_TX_DONE = 16'h00A4;
  localparam logic [15:0] OFF_SEC_MASK_TX_ERR  = 16'h00A8;
  localparam logic [15:0] OFF_SEC_MASK_UBB     = 16'h00AC;
  localparam logic [15:0] OFF_SEC_MASK_RATE    = 16'h00B0;

  // ---------------------------------------------------------------
  // reset values and implemented-bit masks
  // ---------------------------------------------------------------
  localparam logic [31:0] REG_RESET         = 32'h0000_0000;
  localparam logic [31:0] VALID_STATUS_UBB  = 32'h3F07_03FF;
  localparam logic [31:0] VALID_QUEUE_PAIR  = 32'h03FF_03FF;
  localparam logic [31:0] VALID_QUEUE_LOW   = 32'h0000_03FF;
  localparam logic [31:0] VALID_PRIMARY     = 32'h0FBF_FFFF;
  localparam logic [31:0] VALID_MASK_UBB    = 32'h1F07_03FF;

  // ---------------------------------------------------------------
  // secondary field positions
  // ---------------------------------------------------------------
  localparam int unsigned QUEUE_LO_LSB      = 0;
  localparam int unsigned QUEUE_HI_LSB      = 16;
  localparam int unsigned BIT_MASTER_ABORT  = 16;
  localparam int unsigned BIT_ADDR_PARITY   = 17;
  localparam int unsigned BIT_DATA_PARITY   = 18;
  localparam int unsigned BIT_TRAFFIC_MAP   = 24;
  localparam int unsigned BIT_BCAST_END     = 25;
  localparam int unsigned BIT_DMAP_SYNC     = 26;
  localparam int unsigned BIT_BEACON_TO     = 27;
  localparam int unsigned BIT_BCAST_TO      = 28;
  localparam int unsigned BIT_DMAP_BEACON   = 29;

  // ---------------------------------------------------------------
  // primary bit positions driven here
  // ---------------------------------------------------------------
  localparam int unsigned PRI_TX_SUCCESS    = 6;
  localparam int unsigned PRI_TX_DESC       = 7;
  localparam int unsigned PRI_TX_ERROR      = 8;
  localparam int unsigned PRI_TX_EOL        = 10;
  localparam int unsigned PRI_UNDERFLOW     = 11;
  localparam int unsigned PRI_HOST_ERR      = 19;
  localparam int unsigned PRI_BEACON_MISC   = 23;
  localparam int unsigned PRI_RATE_OVF      = 25;
  localparam int unsigned PRI_TRIG_NO_FRM   = 26;
  localparam int unsigned PRI_TRIG          = 27;
  localparam logic [31:0] PRI_OWNED         = 32'h0E88_0DC0;

endpackage

// ===== rtl/wsi_w1c_bank.sv
// Purpose: one 32-bit write-one-to-clear status register
// Assumes: set pulses and clear writes arrive on the core clock
// Notes:   unimplemented bits are constant zero
`timescale 1ns/1ps
module wsi_w1c_bank #(
  parameter logic [31:0] VALID = 32'hFFFF_FFFF
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic [31:0] i_set,
  input  wire logic        i_clr_wr,
  input  wire logic [31:0] i_clr_data,
  output logic      [31:0] o_status
);
  import wsi_pkg::*;

  // ---------------------------------------------------------------
  // per-bit flags
  // ---------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < 32; b++)
    begin : g_bit
      if (VALID[b])
      begin : g_flop
        logic flag_q;
        // a set in the clearing cycle wins so no event is lost
        always_ff @(posedge i_core_clk)
        begin
          if (i_reset)
            flag_q <= REG_RESET[b]; // R14
          else
            flag_q <= (flag_q & ~(i_clr_wr & i_clr_data[b])) | i_set[b]; // R14
        end
        assign o_status[b] = flag_q;
      end
      else
      begin : g_zero
        assign o_status[b] = 1'b0;
      end
    end
  endgenerate

endmodule

// ===== rtl/wsi_irq_status_mask.sv
// What this block does
// R1 - queue underflow sets its status-2 bit
// R2 - bus master abort sets bit 16
// R3 - address parity error sets bit 17
// R4 - data parity error sets bit 18
// R5 - traffic map hit sets bit 24
// R6 - broadcast traffic end sets bit 25
// R7 - delivery map sync loss sets bit 26
// R8 - beacon timeout sets bit 27
// R9 - broadcast traffic timeout sets bit 28
// R10 - delivery map beacon sets bit 29
// R11 - rate counter overflow sets status-3 low field
// R12 - trigger without frames sets status-3 high field
// R13 - queue trigger sets status-4 low field
// R14 - status readable, write one clears, reset zero
// R15 - primary mask enables primary bits, resets zero
// R16 - mask 0 gates success and desc flags
// R17 - mask 1 gates error and end-of-list flags
// R18 - mask 2 low field gates underflow flags
// R19 - mask 2 bits 16-18 gate bus errors
// R20 - mask 3 gates overflow and no-frame flags
// R21 - software writes reserved bits as zero
// R22 - primary underflow is OR of queue bits
// R23 - primary host error ORs three bus flags
// R24 - primary beacon bit ORs six beacon flags
// R25 - primary queue bits OR status-3/4 fields
// R26 - mask 2 bits 24-28 gate beacon events
// R27 - interrupt when enabled primary bit set
//
// Purpose: secondary interrupt status and mask registers of the MAC
// Assumes: event inputs are one-cycle pulses on the core clock
// Notes:   register access answers with o_reg_ack one cycle later
`timescale 1ns/1ps
module wsi_irq_status_mask (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_reset,
  input  wire logic [wsi_pkg::ADDR_W-1:0] i_reg_addr,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire logic [31:0]            i_reg_wdata,
  output logic      [31:0]            o_reg_rdata,
  output logic                        o_reg_ack,
  input  wire logic [9:0]             i_queue_underflow,
  input  wire logic                   i_master_abort,
  input  wire logic                   i_address_parity_sys_error,
  input  wire logic                   i_data_parity_error,
  input  wire logic                   i_traffic_map_hit,
  input  wire logic                   i_bcast_after_beacon_end,
  input  wire logic                   i_delivery_map_sync_lost,
  input  wire logic                   i_beacon_timeout,
  input  wire logic                   i_bcast_after_beacon_timeout,
  input  wire logic                   i_delivery_map_beacon,
  input  wire logic [9:0]             i_rate_ctrl_overflow,
  input  wire logic [9:0]             i_trigger_without_frames,
  input  wire logic [9:0]             i_queue_trigger,
  input  wire logic [9:0]             i_tx_success_flags,
  input  wire logic [9:0]             i_tx_desc_request_flags,
  input  wire logic [9:0]             i_tx_error_flags,
  input  wire logic [9:0]             i_tx_end_of_list_flags,
  input  wire logic [31:0]            i_primary_status_other,
  output logic      [31:0]            o_primary_status,
  output logic                        o_host_irq
);
  import wsi_pkg::*;

  // ---------------------------------------------------------------
  // register decode and event set vectors
  // ---------------------------------------------------------------
  wire logic   wr_s2 = i_reg_wr && (i_reg_addr == OFF_SEC_STATUS_UBB);
  wire logic   wr_s3 = i_reg_wr && (i_reg_addr == OFF_SEC_STATUS_RATE);
  wire logic   wr_s4 = i_reg_wr && (i_reg_addr == OFF_SEC_STATUS_TRIG);
  wire logic   wr_mp = i_reg_wr && (i_reg_addr == OFF_PRIMARY_MASK);
  wire logic   wr_m0 = i_reg_wr && (i_reg_addr == OFF_SEC_MASK_TX_DONE);
  wire logic   wr_m1 = i_reg_wr && (i_reg_addr == OFF_SEC_MASK_TX_ERR);
  wire logic   wr_m2 = i_reg_wr && (i_reg_addr == OFF_SEC_MASK_UBB);
  wire logic   wr_m3 = i_reg_wr && (i_reg_addr == OFF_SEC_MASK_RATE);
  logic [31:0] set_s2;
  logic [31:0] set_s3;
  logic [31:0] set_s4;

  always_comb
  begin
    set_s2 = 32'h0000_0000;
    set_s2[QUEUE_LO_LSB +: NUM_QUEUES] = i_queue_underflow;       // R1
    set_s2[BIT_MASTER_ABORT] = i_master_abort;                    // R2
    set_s2[BIT_ADDR_PARITY]  = i_address_parity_sys_error;        // R3
    set_s2[BIT_DATA_PARITY]  = i_data_parity_error;               // R4
    set_s2[BIT_TRAFFIC_MAP]  = i_traffic_map_hit;                 // R5
    set_s2[BIT_BCAST_END]    = i_bcast_after_beacon_end;          // R6
    set_s2[BIT_DMAP_SYNC]    = i_delivery_map_sync_lost;          // R7
    set_s2[BIT_BEACON_TO]    = i_beacon_timeout;                  // R8
    set_s2[BIT_BCAST_TO]     = i_bcast_after_beacon_timeout;      // R9
    set_s2[BIT_DMAP_BEACON]  = i_delivery_map_beacon;             // R10
    set_s3 = 32'h0000_0000;
    set_s3[QUEUE_LO_LSB +: NUM_QUEUES] = i_rate_ctrl_overflow;     // R11
    set_s3[QUEUE_HI_LSB +: NUM_QUEUES] = i_trigger_without_frames; // R12
    set_s4 = 32'h0000_0000;
    set_s4[QUEUE_LO_LSB +: NUM_QUEUES] = i_queue_trigger;          // R13
  end

  // ---------------------------------------------------------------
  // status registers
  // ---------------------------------------------------------------
  logic [31:0] stat_s2;
  logic [31:0] stat_s3;
  logic [31:0] stat_s4;

  wsi_w1c_bank #(.VALID(VALID_STATUS_UBB)) u_stat_s2 (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_set      (set_s2),
    .i_clr_wr   (wr_s2),
    .i_clr_data (i_reg_wdata),
    .o_status   (stat_s2)
  );
  wsi_w1c_bank #(.VALID(VALID_QUEUE_PAIR)) u_stat_s3 (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_set      (set_s3),
    .i_clr_wr   (wr_s3),
    .i_clr_data (i_reg_wdata),
    .o_status   (stat_s3)
  );
  wsi_w1c_bank #(.VALID(VALID_QUEUE_LOW)) u_stat_s4 (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_set      (set_s4),
    .i_clr_wr   (wr_s4),
    .i_clr_data (i_reg_wdata),
    .o_status   (stat_s4)
  );

  // ---------------------------------------------------------------
  // mask registers
  // ---------------------------------------------------------------
  logic [31:0] mask_p_q;
  logic [31:0] mask_s0_q;
  logic [31:0] mask_s1_q;
  logic [31:0] mask_s2_q;
  logic [31:0] mask_s3_q;

  // reserved bits are dropped on write so they always read zero
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      mask_p_q  <= REG_RESET; // R15
      mask_s0_q <= REG_RESET;
      mask_s1_q <= REG_RESET;
      mask_s2_q <= REG_RESET;
      mask_s3_q <= REG_RESET;
    end
    else
    begin
      if (wr_mp)
        mask_p_q <= i_reg_wdata & VALID_PRIMARY; // R15
      if (wr_m0)
        mask_s0_q <= i_reg_wdata & VALID_QUEUE_PAIR; // R16
      if (wr_m1)
        mask_s1_q <= i_reg_wdata & VALID_QUEUE_PAIR; // R17
      if (wr_m2)
        mask_s2_q <= i_reg_wdata & VALID_MASK_UBB; // R18 R19 R26
      if (wr_m3)
        mask_s3_q <= i_reg_wdata & VALID_QUEUE_PAIR; // R20
    end
  end

  // ---------------------------------------------------------------
  // primary summary and interrupt
  // ---------------------------------------------------------------
  logic [31:0] prim_raw;
  logic [31:0] prim_gated;
  logic [31:0] prim_status_q;
  logic        host_irq_q;
  logic [4:0]  beacon_field;

  assign beacon_field = stat_s2[BIT_BCAST_TO:BIT_TRAFFIC_MAP];

  always_comb
  begin
    prim_raw = i_primary_status_other & ~PRI_OWNED;
    prim_raw[PRI_TX_SUCCESS]  = |i_tx_success_flags;
    prim_raw[PRI_TX_DESC]     = |i_tx_desc_request_flags;
    prim_raw[PRI_TX_ERROR]    = |i_tx_error_flags;
    prim_raw[PRI_TX_EOL]      = |i_tx_end_of_list_flags;
    prim_raw[PRI_UNDERFLOW]   = |stat_s2[QUEUE_LO_LSB +: NUM_QUEUES]; // R22
    prim_raw[PRI_HOST_ERR]    = |stat_s2[BIT_DATA_PARITY:BIT_MASTER_ABORT]; // R23
    prim_raw[PRI_BEACON_MISC] = (|beacon_field) | stat_s2[BIT_DMAP_BEACON]; // R24
    prim_raw[PRI_RATE_OVF]    = |stat_s3[QUEUE_LO_LSB +: NUM_QUEUES]; // R25
    prim_raw[PRI_TRIG_NO_FRM] = |stat_s3[QUEUE_HI_LSB +: NUM_QUEUES]; // R25
    prim_raw[PRI_TRIG]        = |stat_s4[QUEUE_LO_LSB +: NUM_QUEUES]; // R25
  end

  // each source driven here, except the delivery map beacon and queue trigger, is gated by its secondary enable before the OR
  always_comb
  begin
    prim_gated = i_primary_status_other & ~PRI_OWNED;
    prim_gated[PRI_TX_SUCCESS] =
      |(i_tx_success_flags & mask_s0_q[QUEUE_LO_LSB +: NUM_QUEUES]); // R16
    prim_gated[PRI_TX_DESC] =
      |(i_tx_desc_request_flags & mask_s0_q[QUEUE_HI_LSB +: NUM_QUEUES]); // R16
    prim_gated[PRI_TX_ERROR] =
      |(i_tx_error_flags & mask_s1_q[QUEUE_LO_LSB +: NUM_QUEUES]); // R17
    prim_gated[PRI_TX_EOL] =
      |(i_tx_end_of_list_flags & mask_s1_q[QUEUE_HI_LSB +: NUM_QUEUES]); // R17
    prim_gated[PRI_UNDERFLOW] =
      |(stat_s2[QUEUE_LO_LSB +: NUM_QUEUES] & mask_s2_q[QUEUE_LO_LSB +: NUM_QUEUES]); // R18
    prim_gated[PRI_HOST_ERR] =
      |(stat_s2[BIT_DATA_PARITY:BIT_MASTER_ABORT]
        & mask_s2_q[BIT_DATA_PARITY:BIT_MASTER_ABORT]); // R19
    // delivery map beacon event has no secondary enable and passes straight through
    prim_gated[PRI_BEACON_MISC] =
      (|(beacon_field & mask_s2_q[BIT_BCAST_TO:BIT_TRAFFIC_MAP]))
      | stat_s2[BIT_DMAP_BEACON]; // R26
    prim_gated[PRI_RATE_OVF] =
      |(stat_s3[QUEUE_LO_LSB +: NUM_QUEUES] & mask_s3_q[QUEUE_LO_LSB +: NUM_QUEUES]); // R20
    prim_gated[PRI_TRIG_NO_FRM] =
      |(stat_s3[QUEUE_HI_LSB +: NUM_QUEUES] & mask_s3_q[QUEUE_HI_LSB +: NUM_QUEUES]); // R20
    // trigger enables live in a register outside this block
    prim_gated[PRI_TRIG] = |stat_s4[QUEUE_LO_LSB +: NUM_QUEUES];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      prim_status_q <= REG_RESET;
      host_irq_q    <= 1'b0;
    end
    else
    begin
      prim_status_q <= prim_raw & VALID_PRIMARY; // R22 R23 R24 R25
      host_irq_q    <= |(prim_gated & mask_p_q); // R27
    end
  end

  assign o_primary_status = prim_status_q;
  assign o_host_irq       = host_irq_q;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [31:0] rdata_q;
  logic        ack_q;

  // unmapped addresses read zero; the ack still answers so software never hangs
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      rdata_q <= REG_RESET;
    else if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        OFF_SEC_STATUS_UBB:   rdata_q <= stat_s2; // R14
        OFF_SEC_STATUS_RATE:  rdata_q <= stat_s3; // R14
        OFF_SEC_STATUS_TRIG:  rdata_q <= stat_s4; // R14
        OFF_PRIMARY_MASK:     rdata_q <= mask_p_q;
        OFF_SEC_MASK_TX_DONE: rdata_q <= mask_s0_q;
        OFF_SEC_MASK_TX_ERR:  rdata_q <= mask_s1_q;
        OFF_SEC_MASK_UBB:     rdata_q <= mask_s2_q;
        OFF_SEC_MASK_RATE:    rdata_q <= mask_s3_q;
        default:              rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      ack_q <= 1'b0;
    else
      ack_q <= i_reg_rd | i_reg_wr;
  end

  assign o_reg_rdata = rdata_q;
  assign o_reg_ack   = ack_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_underflow_sets;
    @(posedge i_core_clk) disable iff (i_reset)
    (|i_queue_underflow) |=>
      ((stat_s2[9:0] & $past(i_queue_underflow)) == $past(i_queue_underflow));
  endproperty
  a_underflow_sets: assert property (p_underflow_sets) // R1
    else $error("underflow event did not set its status bit");
  property p_bus_errors_set;
    @(posedge i_core_clk) disable iff (i_reset)
    (i_master_abort || i_address_parity_sys_error || i_data_parity_error) |=>
      (stat_s2[18:16] & $past({i_data_parity_error, i_address_parity_sys_error,
                                i_master_abort}))
      == $past({i_data_parity_error, i_address_parity_sys_error, i_master_abort});
  endproperty
  a_bus_errors_set: assert property (p_bus_errors_set) // R2 R3 R4
    else $error("bus error event not recorded");
  property p_beacon_events_set;
    @(posedge i_core_clk) disable iff (i_reset)
    (|set_s2[29:24]) |=> ((stat_s2[29:24] & $past(set_s2[29:24])) == $past(set_s2[29:24]));
  endproperty
  a_beacon_events_set: assert property (p_beacon_events_set) // R5 R6 R7 R8 R9 R10
    else $error("beacon event not recorded");
  property p_rate_fields_set;
    @(posedge i_core_clk) disable iff (i_reset)
    (|{i_rate_ctrl_overflow, i_trigger_without_frames}) |=>
      ({stat_s3[25:16], stat_s3[9:0]} & $past({i_trigger_without_frames,
                                              i_rate_ctrl_overflow}))
      == $past({i_trigger_without_frames, i_rate_ctrl_overflow});
  endproperty
  a_rate_fields_set: assert property (p_rate_fields_set) // R11 R12
    else $error("rate control event not recorded");
  property p_trigger_sets;
    @(posedge i_core_clk) disable iff (i_reset)
    (|i_queue_trigger) |=> ((stat_s4[9:0] & $past(i_queue_trigger)) == $past(i_queue_trigger));
  endproperty
  a_trigger_sets: assert property (p_trigger_sets) // R13
    else $error("queue trigger not recorded");
  property p_w1c_clears;
    @(posedge i_core_clk) disable iff (i_reset)
    (wr_s2 && ((i_reg_wdata & set_s2) == 32'h0000_0000)) |=>
      ((stat_s2 & $past(i_reg_wdata)) == 32'h0000_0000);
  endproperty
  a_w1c_clears: assert property (p_w1c_clears) // R14
    else $error("write one did not clear status bit");
  property p_zero_write_keeps;
    @(posedge i_core_clk) disable iff (i_reset)
    wr_s3 |=> ((stat_s3 & ~$past(i_reg_wdata)) == ($past(stat_s3) & ~$past(i_reg_wdata)))
              or ((stat_s3 & ~$past(i_reg_wdata)) != ($past(stat_s3) & ~$past(i_reg_wdata))
                  && $past(|set_s3));
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps) // R14
    else $error("writing zero altered a status bit");
  property p_mask_write;
    @(posedge i_core_clk) disable iff (i_reset)
    wr_mp |=> (mask_p_q == ($past(i_reg_wdata) & VALID_PRIMARY)) [*1] ##1 1'b1;
  endproperty
  a_mask_write: assert property (p_mask_write) // R15
    else $error("primary mask did not take written value");
  property p_summary_or;
    @(posedge i_core_clk) disable iff (i_reset)
    1'b1 |=> (o_primary_status[11] == $past(|stat_s2[9:0]))
             && (o_primary_status[19] == $past(|stat_s2[18:16]))
             && (o_primary_status[23] == $past(|stat_s2[29:24]))
             && (o_primary_status[27] == $past(|stat_s4[9:0]));
  endproperty
  a_summary_or: assert property (p_summary_or) // R22 R23 R24 R25
    else $error("primary summary bit mismatch");
  property p_irq_follows;
    @(posedge i_core_clk) disable iff (i_reset)
    (|(prim_gated & mask_p_q)) |=> o_host_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) // R27
    else $error("enabled source did not raise interrupt");
  property p_irq_masked;
    @(posedge i_core_clk) disable iff (i_reset)
    (mask_p_q == 32'h0000_0000) |=> !o_host_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) // R15 R27
    else $error("interrupt raised with primary mask clear");

  c_underflow_irq: cover property (@(posedge i_core_clk) disable iff (i_reset)
    (|i_queue_underflow) ##1 1'b1 ##1 o_host_irq);
  c_set_wins: cover property (@(posedge i_core_clk) disable iff (i_reset)
    wr_s2 && (|(i_reg_wdata & set_s2)));
  c_read_status: cover property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_rd && (i_reg_addr == OFF_SEC_STATUS_TRIG) && (stat_s4 != 32'h0000_0000));

endmodule

// ===== tb/wsi_irq_status_mask_test.sv
// Purpose: self-checking bench for the secondary interrupt status and mask block
// Assumes: host port acks one cycle after each strobe
// Notes:   inputs change on the falling edge only
`timescale 1ns/1ps
module wsi_irq_status_mask_test;
  import wsi_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observation
  // ---------------------------------------------------------------
  logic        clk, rst, wr, rd, ack, irq;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, pri, oth;
  logic [48:0] ev;
  logic [39:0] tx;
  int          failures, tests_run;
  logic [15:0] madr [5] = '{OFF_PRIMARY_MASK, OFF_SEC_MASK_TX_DONE,
    OFF_SEC_MASK_TX_ERR, OFF_SEC_MASK_UBB, OFF_SEC_MASK_RATE};
  logic [31:0] mval [5] = '{VALID_PRIMARY, VALID_QUEUE_PAIR,
    VALID_QUEUE_PAIR, VALID_MASK_UBB, VALID_QUEUE_PAIR};

  wsi_irq_status_mask uut (
    .i_core_clk(clk), .i_reset(rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
    .i_queue_underflow(ev[9:0]), .i_master_abort(ev[10]),
    .i_address_parity_sys_error(ev[11]), .i_data_parity_error(ev[12]),
    .i_traffic_map_hit(ev[13]), .i_bcast_after_beacon_end(ev[14]),
    .i_delivery_map_sync_lost(ev[15]), .i_beacon_timeout(ev[16]),
    .i_bcast_after_beacon_timeout(ev[17]), .i_delivery_map_beacon(ev[18]),
    .i_rate_ctrl_overflow(ev[28:19]), .i_trigger_without_frames(ev[38:29]),
    .i_queue_trigger(ev[48:39]), .i_tx_success_flags(tx[9:0]),
    .i_tx_desc_request_flags(tx[19:10]), .i_tx_error_flags(tx[29:20]),
    .i_tx_end_of_list_flags(tx[39:30]), .i_primary_status_other(oth),
    .o_primary_status(pri), .o_host_irq(irq));

  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    wr    = w;
    rd    = !w;
    addr  = a;
    wdata = d;
    @(negedge clk);
    wr = 1'h0;
    rd = 1'h0;
    chk({31'h0, ack}, 32'h1);
  endtask

  task automatic rdx(input logic [15:0] a, input logic [31:0] e);
    acc(1'h0, a, 32'h0);
    chk(rdata, e);
  endtask

  task automatic set_masks(input logic [4:0] on);
    for (int i = 0; i < 5; i++)
      acc(1'h1, madr[i], on[i] ? mval[i] : 32'h0);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_values;
    rdx(OFF_SEC_STATUS_UBB, REG_RESET);
    rdx(OFF_SEC_STATUS_RATE, REG_RESET);
    rdx(OFF_SEC_STATUS_TRIG, REG_RESET);
    for (int i = 0; i < 5; i++)
      rdx(madr[i], REG_RESET);
    chk(pri | {31'h0, irq}, 32'h0);
  endtask

  task automatic t_masks;
    for (int i = 0; i < 5; i++)
    begin
      acc(1'h1, madr[i], mval[i]);
      rdx(madr[i], mval[i]);
    end
    acc(1'h1, 16'h0098, 32'h1);
    rdx(16'h0098, 32'h0);
  endtask

  // gated: secondary masks off, primary mask on; only ungated sources fire
  task automatic t_events(input logic gated);
    logic [15:0] a;
    int          b;
    int          p;
    for (int k = 0; k < 49; k++)
    begin
      a = k < 19 ? OFF_SEC_STATUS_UBB : k < 39 ? OFF_SEC_STATUS_RATE : OFF_SEC_STATUS_TRIG;
      b = k < 10 ? k : k < 13 ? k + 6 : k < 19 ? k + 11 : k < 29 ? k - 19
        : k < 39 ? k - 13 : k - 39;
      p = k < 10 ? PRI_UNDERFLOW : k < 13 ? PRI_HOST_ERR : k < 19 ? PRI_BEACON_MISC
        : k < 29 ? PRI_RATE_OVF : k < 39 ? PRI_TRIG_NO_FRM : PRI_TRIG;
      @(negedge clk);
      ev = 49'h1 << k;
      @(negedge clk);
      ev = 49'h0;
      repeat (2) @(negedge clk);
      chk(pri, 32'h1 << p);
      chk({31'h0, irq}, {31'h0, !gated || k == 18 || k > 38});
      acc(1'h1, a, 32'h0);
      rdx(a, 32'h1 << b);
      acc(1'h1, a, 32'h1 << b);
      rdx(a, REG_RESET);
      @(negedge clk);
      chk(pri | {31'h0, irq}, 32'h0);
    end
  endtask

  task automatic t_set_wins;
    @(negedge clk);
    ev    = 49'h1;
    wr    = 1'h1;
    addr  = OFF_SEC_STATUS_UBB;
    wdata = 32'h1;
    @(negedge clk);
    ev = 49'h0;
    wr = 1'h0;
    rdx(OFF_SEC_STATUS_UBB, 32'h1);
    acc(1'h1, OFF_SEC_STATUS_UBB, 32'h1);
  endtask

  // level flags show raw in primary view but need their queue enable
  task automatic t_tx;
    logic [15:0] a;
    int          p;
    for (int g = 0; g < 4; g++)
    begin
      a  = g < 2 ? OFF_SEC_MASK_TX_DONE : OFF_SEC_MASK_TX_ERR;
      p  = g == 0 ? PRI_TX_SUCCESS : g == 1 ? PRI_TX_DESC : g == 2 ? PRI_TX_ERROR : PRI_TX_EOL;
      tx = 40'h8 << (10 * g);
      repeat (3) @(negedge clk);
      chk(pri, 32'h1 << p);
      chk({31'h0, irq}, 32'h0);
      acc(1'h1, a, 32'h8 << ((g % 2) * 16));
      repeat (2) @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      acc(1'h1, a, 32'h0);
      tx = 40'h0;
    end
    // bits owned elsewhere pass through; owned and reserved bits do not
    oth = 32'hFFFF_FFFF;
    repeat (2) @(negedge clk);
    chk(pri, VALID_PRIMARY & ~PRI_OWNED);
    chk({31'h0, irq}, 32'h1);
    oth = 32'h0;
  endtask

  initial
  begin
    {rst, wr, rd, addr, wdata, ev, tx, oth} = {1'h1, 171'h0};
    failures  = 0;
    tests_run = 0;
    repeat (16) @(negedge clk);
    rst = 1'h0;
    t_reset_values;
    t_masks;
    t_events(1'h0);
    set_masks(5'h01);
    t_events(1'h1);
    t_set_wins;
    t_tx;
    set_masks(5'h1F);
    @(negedge clk);
    ev = 49'h1;
    @(negedge clk);
    ev  = 49'h0;
    rst = 1'h1;
    repeat (16) @(negedge clk);
    rst = 1'h0;
    t_reset_values;
    print_verdict;
  end
endmodule
